// *** hw/mdap_dev.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Byte FIFO between link and loader
// ----------------------------------------
module mdap_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16   // Power of two
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;  // Storage
    logic [AW-1:0]           wp;   // Write pointer
    logic [AW-1:0]           rp;   // Read pointer
    logic [AW:0]             cnt;  // Fill level
    logic                    rdy;  // Registered not-full
  } mdap_fifo_s;
  mdap_fifo_s q_r, q_nxt;
  logic push, pop;

  // Push and pop may both happen in one cycle
  always_comb begin
    q_nxt = q_r;
    push  = in_valid && q_r.rdy;
    pop   = out_ready && (q_r.cnt != '0);
    if (push) begin
      q_nxt.mem[q_r.wp] = in_data;
      q_nxt.wp          = q_r.wp + 1'b1;
    end
    if (pop) begin
      q_nxt.rp = q_r.rp + 1'b1;
    end
    q_nxt.cnt = q_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    q_nxt.rdy = (q_nxt.cnt != DEPTH[AW:0]);  // Full stalls the link
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q_r     <= '0;
      q_r.rdy <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign in_ready  = q_r.rdy;
  assign out_valid = (q_r.cnt != '0);
  assign out_data  = q_r.mem[q_r.rp];
endmodule

// ----------------------------------------
// Memory download and peek/poke access unit
// ----------------------------------------
module mdap_dev #(
  parameter logic [31:0] VERSION = 32'h0000_0001  // Arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  mdap_if.dev              lnk,
  input  wire logic [23:0] fw_status,
  input  wire logic        div_show,
  output logic             mem_wr_valid,
  input  wire logic        mem_wr_ready,
  output logic [15:0]      mem_sel,
  output logic [15:0]      mem_addr,
  output logic [63:0]      mem_data,
  output logic             pp_valid,
  output logic             pp_write,
  output logic [7:0]       pp_sel,
  output logic [15:0]      pp_addr,
  output logic [63:0]      pp_wdata,
  input  wire logic        pp_done,
  input  wire logic [63:0] pp_rdata
);
  import mdap_pkg::*;

  typedef struct packed {
    mdap_ld_e    st;      // Download phase
    logic [2:0]  hcnt;    // Header bytes seen
    logic [63:0] hdr;     // Header shifter
    logic [15:0] sel;     // Memory being loaded
    logic [15:0] waddr;   // Next word address
    logic [15:0] left;    // Payload bytes still due
    logic [15:0] sum;     // Running checksum
    logic [15:0] hcks;    // Checksum from header
    logic [7:0]  crx;     // First trailing checksum byte
    logic        cfirst;  // Waiting for first checksum byte
    logic [63:0] asm;     // Word assembler
    logic [2:0]  acnt;    // Bytes in assembler
    logic [4:0]  err;     // Per-memory load errors
    logic        inval;   // Invalid select seen
    logic        eol;     // End-of-load header error
    logic [31:0] sa;      // Select and address register
    logic [63:0] ppd;     // Peek/poke data register
    logic        rsp_valid;
    logic [7:0]  rsp_byte;
    logic        mwv;
    logic [15:0] msel;
    logic [15:0] maddr;
    logic [63:0] mdata;
    logic        ppv;
    logic        ppw;
    logic [7:0]  pps;
    logic [15:0] ppa;
  } mdap_dev_s;
  mdap_dev_s q_r, q_nxt;

  logic             f_in_valid, f_ready, f_out_valid, f_pop;
  logic [FIFO_W-1:0] f_out;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Error flag for each selector; two selectors have none
  function automatic logic [4:0] err_bit(input logic [15:0] s);
    err_bit = 5'h00;
    case (s)
      MSEL_UPROG:  err_bit[ST_ERR_UPROG]  = 1'b1;
      MSEL_UXDATA: err_bit[ST_ERR_UXDATA] = 1'b1;
      MSEL_DPROG:  err_bit[ST_ERR_DPROG]  = 1'b1;
      MSEL_DUCOEF: err_bit[ST_ERR_DUCOEF] = 1'b1;
      MSEL_DUDATA: err_bit[ST_ERR_DUDATA] = 1'b1;
      default:     err_bit = 5'h00;
    endcase
  endfunction

  // Last byte index of a word and its mask, per memory
  function automatic logic [2:0] w_last(input logic [15:0] s);
    case (s)
      MSEL_UPROG, MSEL_UXDATA: w_last = 3'h0;
      MSEL_DCOEF, MSEL_DUCOEF: w_last = LAST_IDX_32;
      default:                 w_last = LAST_IDX_64;
    endcase
  endfunction

  function automatic logic [63:0] w_mask(input logic [15:0] s);
    case (s)
      MSEL_UPROG, MSEL_UXDATA: w_mask = W8_MASK;
      MSEL_DCOEF, MSEL_DUCOEF: w_mask = W28_MASK;
      MSEL_DPROG:              w_mask = W54_MASK;
      default:                 w_mask = W48_MASK;
    endcase
  endfunction

  // Byte idx of a register, MSB first; past the end reads zero
  function automatic logic [7:0] pick(input logic [63:0] v, input logic [2:0] last,
                                     input logic [2:0] idx);
    logic [63:0] s;
    s    = v >> {3'(last - idx), 3'b000};
    pick = (idx > last) ? 8'h00 : s[7:0];
  endfunction

  // Address field is stored with its bits reversed
  function automatic logic [15:0] rev16(input logic [15:0] a);
    for (int i = 0; i < 16; i++) begin
      rev16[i] = a[15-i];
    end
  endfunction

  function automatic logic pp_ok(input logic [7:0] t);
    pp_ok = (t >= PP_DCOEF) && (t <= PP_DUPPER) && (t != PP_RSVD);
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [63:0] hn;
    logic [63:0] an;
    logic [7:0]  b;
    logic [7:0]  low;
    logic [15:0] hs;
    logic [31:0] san;
    hn  = '0;
    an  = '0;
    b   = f_out[7:0];
    low = 8'h00;
    hs  = 16'h0000;
    san = '0;
    q_nxt = q_r;
    q_nxt.rsp_valid = 1'b0;
    // Retire handshakes before new work may start
    if (q_r.mwv && mem_wr_ready) begin
      q_nxt.mwv = 1'b0;
    end
    if (q_r.ppv && pp_done) begin
      q_nxt.ppv = 1'b0;
      if (!q_r.ppw) begin
        q_nxt.ppd = pp_rdata;
      end
    end
    // Link access; header and payload bytes go through the FIFO
    if (lnk.req_valid && f_ready) begin
      if (!lnk.req_write) begin
        q_nxt.rsp_valid = 1'b1;
        if (div_show) begin
          low = ST_DIV_CODE;
        end else if (q_r.eol) begin
          low = ST_EOL_CODE;
        end else begin
          low = {2'b00, q_r.inval, q_r.err};
        end
        case (lnk.req_addr)
          REG_STATUS: q_nxt.rsp_byte = pick({32'h0, fw_status, low}, LAST_IDX_32, lnk.req_idx);
          REG_SA:     q_nxt.rsp_byte = pick({32'h0, q_r.sa}, LAST_IDX_32, lnk.req_idx);
          REG_PPD:    q_nxt.rsp_byte = pick(q_r.ppd, LAST_IDX_64, lnk.req_idx);
          REG_VER:    q_nxt.rsp_byte = pick({32'h0, VERSION}, LAST_IDX_32, lnk.req_idx);
          default:    q_nxt.rsp_byte = 8'h00;
        endcase
      end else if (lnk.req_addr == REG_SA) begin
        san      = {q_r.sa[23:0], lnk.req_wbyte};
        q_nxt.sa = san;
        // Completing the address starts a peek
        if (lnk.req_idx == LAST_IDX_32 && !q_r.ppv && pp_ok(san[23:16])) begin
          q_nxt.ppv = 1'b1;
          q_nxt.ppw = 1'b0;
          q_nxt.pps = san[23:16];
          q_nxt.ppa = rev16(san[15:0]);
        end
      end else if (lnk.req_addr == REG_PPD) begin
        q_nxt.ppd = {q_r.ppd[55:0], lnk.req_wbyte};
        // Completing the data word starts a poke
        if (lnk.req_idx == LAST_IDX_64 && !q_r.ppv && pp_ok(q_r.sa[23:16])) begin
          q_nxt.ppv = 1'b1;
          q_nxt.ppw = 1'b1;
          q_nxt.pps = q_r.sa[23:16];
          q_nxt.ppa = rev16(q_r.sa[15:0]);
        end
      end
    end
    // Loader drains the FIFO, stalled by a pending memory write
    if (f_pop) begin
      if (f_out[8]) begin
        hn         = {q_r.hdr[55:0], b};
        q_nxt.hdr  = hn;
        q_nxt.hcnt = q_r.hcnt + 3'h1;
        if (q_r.hcnt == LAST_IDX_64) begin
          hs = 16'(hn[47:40]) + 16'(hn[39:32]) + 16'(hn[31:24])
             + 16'(hn[23:16]) + 16'(hn[15:8]) + 16'(hn[7:0]);
          if (hn[63:48] == 16'h0 && hn[31:0] == 32'h0) begin
            q_nxt.eol = (q_r.st != MDAP_IDLE);
            q_nxt.st  = MDAP_IDLE;
          end else if (hn[47:32] > MSEL_DUCOEF) begin
            q_nxt.inval = 1'b1;
            q_nxt.eol   = 1'b0;
            q_nxt.st    = MDAP_IDLE;
          end else begin
            q_nxt.inval  = 1'b0;
            q_nxt.eol    = 1'b0;
            q_nxt.err    = q_r.err | err_bit(hn[47:32]);
            q_nxt.sel    = hn[47:32];
            q_nxt.hcks   = hn[63:48];
            q_nxt.waddr  = hn[31:16];
            q_nxt.left   = hn[15:0];
            q_nxt.sum    = hs;
            q_nxt.acnt   = 3'h0;
            q_nxt.cfirst = 1'b1;
            q_nxt.st     = (hn[15:0] == 16'h0) ? MDAP_CKS : MDAP_LOAD;
          end
        end
      end else begin
        case (q_r.st)
          MDAP_LOAD: begin
            an         = {q_r.asm[55:0], b};
            q_nxt.asm  = an;
            q_nxt.sum  = q_r.sum + 16'(b);
            q_nxt.left = q_r.left - 16'h1;
            if (q_r.acnt == w_last(q_r.sel)) begin
              q_nxt.mwv   = 1'b1;
              q_nxt.msel  = q_r.sel;
              q_nxt.maddr = q_r.waddr;
              q_nxt.mdata = an & w_mask(q_r.sel);
              q_nxt.waddr = q_r.waddr + 16'h1;
              q_nxt.acnt  = 3'h0;
            end else begin
              q_nxt.acnt  = q_r.acnt + 3'h1;
            end
            if (q_r.left == 16'h1) begin
              q_nxt.st = MDAP_CKS;
            end
          end
          MDAP_CKS: begin
            if (q_r.cfirst) begin
              q_nxt.crx    = b;
              q_nxt.cfirst = 1'b0;
            end else begin
              // A mismatch keeps the flag set
              if ({q_r.crx, b} == q_r.sum && q_r.hcks == q_r.sum) begin
                q_nxt.err = q_r.err & ~err_bit(q_r.sel);
              end
              q_nxt.st = MDAP_IDLE;
            end
          end
          default: ;  // Stray payload outside a load is dropped
        endcase
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q_r     <= '0;
      q_r.st  <= MDAP_IDLE;
      q_r.sa  <= SA_RST;
      q_r.ppd <= PPD_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // Header and payload buffer
  // ----------------------------------------
  assign f_in_valid = lnk.req_valid && lnk.req_write
                   && (lnk.req_addr == REG_HDR || lnk.req_addr == REG_PAY);
  assign f_pop      = f_out_valid && (!q_r.mwv || mem_wr_ready);

  mdap_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) mdap_fifo_i (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (f_in_valid),
    .in_ready  (f_ready),
    .in_data   ({lnk.req_addr == REG_HDR, lnk.req_wbyte}),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out)
  );

  assign lnk.req_ready = f_ready;
  assign lnk.rsp_valid = q_r.rsp_valid;
  assign lnk.rsp_byte  = q_r.rsp_byte;
  assign mem_wr_valid  = q_r.mwv;
  assign mem_sel       = q_r.msel;
  assign mem_addr      = q_r.maddr;
  assign mem_data      = q_r.mdata;
  assign pp_valid      = q_r.ppv;
  assign pp_write      = q_r.ppw;
  assign pp_sel        = q_r.pps;
  assign pp_addr       = q_r.ppa;
  assign pp_wdata      = q_r.ppd;
endmodule

// *** hw/mdap_pkg.sv ***
package mdap_pkg;
  // ----------------------------------------
  // Register offsets on the link
  // ----------------------------------------
  localparam logic [7:0]  REG_STATUS   = 8'h02;  // Load status
  localparam logic [7:0]  REG_HDR      = 8'h04;  // Download header
  localparam logic [7:0]  REG_PAY      = 8'h05;  // Download payload
  localparam logic [7:0]  REG_SA       = 8'h06;  // Peek/poke select and address
  localparam logic [7:0]  REG_PPD      = 8'h07;  // Peek/poke data
  localparam logic [7:0]  REG_VER      = 8'h08;  // Version word
  // Index of the last byte of each register, first byte is the MSB
  localparam logic [2:0]  LAST_IDX_32  = 3'h3;
  localparam logic [2:0]  LAST_IDX_64  = 3'h7;
  localparam logic [2:0]  CKS_LAST_IDX = 3'h1;
  localparam logic [2:0]  CKS_FIRST_IDX = 3'h2;  // First header byte in the sum
  // ----------------------------------------
  // Download memory selector codes
  // ----------------------------------------
  localparam logic [15:0] MSEL_UPROG   = 16'h0000;
  localparam logic [15:0] MSEL_UXDATA  = 16'h0001;
  localparam logic [15:0] MSEL_DPROG   = 16'h0002;
  localparam logic [15:0] MSEL_DCOEF   = 16'h0003;
  localparam logic [15:0] MSEL_DDATA   = 16'h0004;
  localparam logic [15:0] MSEL_DUDATA  = 16'h0005;
  localparam logic [15:0] MSEL_DUCOEF  = 16'h0006;
  // ----------------------------------------
  // Status low byte fields and codes
  // ----------------------------------------
  localparam int          ST_ERR_UPROG  = 0;
  localparam int          ST_ERR_UXDATA = 1;
  localparam int          ST_ERR_DPROG  = 2;
  localparam int          ST_ERR_DUCOEF = 3;
  localparam int          ST_ERR_DUDATA = 4;
  localparam logic [7:0]  ST_EOL_CODE   = 8'hF0;
  localparam logic [7:0]  ST_DIV_CODE   = 8'hFF;
  localparam int          SAMP_CLK_MHZ  = 33;    // Divided by 2N
  // ----------------------------------------
  // Peek/poke targets, field at bits 23..16
  // ----------------------------------------
  localparam int          PP_SEL_LSB   = 16;
  localparam logic [7:0]  PP_DCOEF     = 8'h01;
  localparam logic [7:0]  PP_DDATA     = 8'h02;
  localparam logic [7:0]  PP_RSVD      = 8'h03;
  localparam logic [7:0]  PP_DUPPER    = 8'h09;
  // ----------------------------------------
  // Word packing and reset values
  // ----------------------------------------
  localparam logic [63:0] W28_MASK     = 64'h0000_0000_0FFF_FFFF;
  localparam logic [63:0] W48_MASK     = 64'h0000_FFFF_FFFF_FFFF;
  localparam logic [63:0] W54_MASK     = 64'h003F_FFFF_FFFF_FFFF;
  localparam logic [63:0] W8_MASK      = 64'h0000_0000_0000_00FF;
  localparam logic [31:0] SA_RST       = 32'h0000_0000;
  localparam logic [63:0] PPD_RST      = 64'h0000_0000_0000_0000;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          FIFO_W       = 9;       // Header tag plus byte
  // ----------------------------------------
  // State encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    MDAP_IDLE = 2'b00,
    MDAP_LOAD = 2'b01,
    MDAP_CKS  = 2'b10
  } mdap_ld_e;
  typedef enum logic [1:0] {
    MDAP_H_IDLE = 2'b00,
    MDAP_H_SEND = 2'b01,
    MDAP_H_WAIT = 2'b10
  } mdap_hs_e;
endpackage

// *** hw/mdap_if.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Byte-wide register link between controller and loader
// ----------------------------------------
interface mdap_if;
  logic       req_valid;  // Controller offers one register byte
  logic       req_ready;  // Loader takes it
  logic       req_write;  // Write when high, read otherwise
  logic [7:0] req_addr;   // Register offset
  logic [2:0] req_idx;    // Byte position, 0 is the MSB
  logic [7:0] req_wbyte;  // Write byte
  logic       rsp_valid;  // Read byte returned
  logic [7:0] rsp_byte;   // Read byte
  modport dev (
    input  req_valid, req_write, req_addr, req_idx, req_wbyte,
    output req_ready, rsp_valid, rsp_byte
  );
  modport host (
    output req_valid, req_write, req_addr, req_idx, req_wbyte,
    input  req_ready, rsp_valid, rsp_byte
  );
endinterface

// *** hw/mdap_host.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Controller end: register byte master with checksum
// ----------------------------------------
module mdap_host (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  mdap_if.host             lnk,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [3:0]  cmd_len,
  input  wire logic [63:0] cmd_data,
  input  wire logic        cmd_cks,
  output logic             rsp_valid,
  output logic [63:0]      rsp_data
);
  import mdap_pkg::*;

  typedef struct packed {
    mdap_hs_e    st;       // Transfer phase
    logic        wr;       // Write command
    logic [7:0]  addr;     // Target register
    logic [2:0]  idx;      // Current byte
    logic [2:0]  last;     // Last byte index
    logic [63:0] data;     // Outgoing bytes, MSB first
    logic        cks_tx;   // Sending the trailing checksum
    logic [15:0] sum;      // Running download checksum
    logic        req_valid;
    logic        cmd_ready;
    logic        rsp_valid;
    logic [63:0] rsp_data;
  } mdap_host_s;
  mdap_host_s q_r, q_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [7:0] b;
    b = q_r.data[63:56];
    q_nxt = q_r;
    q_nxt.rsp_valid = 1'b0;
    case (q_r.st)
      MDAP_H_IDLE: begin
        if (cmd_valid && q_r.cmd_ready) begin
          q_nxt.wr        = cmd_write;
          q_nxt.addr      = cmd_addr;
          q_nxt.idx       = 3'h0;
          // Checksum goes out as two bytes after the payload
          q_nxt.cks_tx    = cmd_cks;
          q_nxt.data      = cmd_cks ? {q_r.sum, 48'h0} : cmd_data;
          q_nxt.last      = cmd_cks ? CKS_LAST_IDX : 3'(cmd_len[2:0] - 3'h1);
          q_nxt.rsp_data  = '0;
          q_nxt.req_valid = 1'b1;
          q_nxt.cmd_ready = 1'b0;
          q_nxt.st        = MDAP_H_SEND;
        end
      end
      MDAP_H_SEND: begin
        if (q_r.req_valid && lnk.req_ready) begin
          if (q_r.wr) begin
            // Header bytes from index 2, then all payload, are summed
            if (q_r.addr == REG_HDR) begin
              if (q_r.idx < CKS_FIRST_IDX) begin
                q_nxt.sum = 16'h0000;
              end else begin
                q_nxt.sum = q_r.sum + 16'(b);
              end
            end else if (q_r.addr == REG_PAY && !q_r.cks_tx) begin
              q_nxt.sum = q_r.sum + 16'(b);
            end
            q_nxt.data = {q_r.data[55:0], 8'h00};
            if (q_r.idx == q_r.last) begin
              q_nxt.req_valid = 1'b0;
              q_nxt.cmd_ready = 1'b1;
              q_nxt.rsp_valid = 1'b1;
              q_nxt.st        = MDAP_H_IDLE;
            end else begin
              q_nxt.idx = q_r.idx + 3'h1;
            end
          end else begin
            q_nxt.req_valid = 1'b0;
            q_nxt.st        = MDAP_H_WAIT;
          end
        end
      end
      MDAP_H_WAIT: begin
        // One read byte outstanding at a time
        if (lnk.rsp_valid) begin
          q_nxt.rsp_data = {q_r.rsp_data[55:0], lnk.rsp_byte};
          if (q_r.idx == q_r.last) begin
            q_nxt.cmd_ready = 1'b1;
            q_nxt.rsp_valid = 1'b1;
            q_nxt.st        = MDAP_H_IDLE;
          end else begin
            q_nxt.idx       = q_r.idx + 3'h1;
            q_nxt.req_valid = 1'b1;
            q_nxt.st        = MDAP_H_SEND;
          end
        end
      end
      default: q_nxt.st = MDAP_H_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q_r           <= '0;
      q_r.st        <= MDAP_H_IDLE;
      q_r.cmd_ready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign lnk.req_valid = q_r.req_valid;
  assign lnk.req_write = q_r.wr;
  assign lnk.req_addr  = q_r.addr;
  assign lnk.req_idx   = q_r.idx;
  assign lnk.req_wbyte = q_r.data[63:56];
  assign cmd_ready     = q_r.cmd_ready;
  assign rsp_valid     = q_r.rsp_valid;
  assign rsp_data      = q_r.rsp_data;
endmodule

// *** tb/mdap_chk.sv ***
`timescale 1ns/1ps
module mdap_chk
  import mdap_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic       req_write,
  input wire logic [7:0] req_addr,
  input wire logic [2:0] req_idx,
  input wire logic [7:0] req_wbyte,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_byte
);
  // ----------------------------------------
  // Link timing and read values
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire rd_t = req_valid && req_ready && !req_write;  // Read byte taken
  wire lo_t = rd_t && req_idx == LAST_IDX_32;        // Low byte of a 32-bit read
  property p_rd_rsp; rd_t |=> rsp_valid; endproperty
  a_rd_rsp: assert property (p_rd_rsp) else $error("read without answer");
  property p_rsp_src; rsp_valid |-> $past(rd_t); endproperty
  a_rsp_src: assert property (p_rsp_src) else $error("stray answer");
  property p_wr_quiet; req_valid && req_ready && req_write |=> !rsp_valid; endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write answered");
  // A stalled byte must not change under the loader, or the sum breaks
  property p_hold;
    req_valid && !req_ready |=> req_valid && $stable({req_write, req_addr, req_idx, req_wbyte});
  endproperty
  a_hold: assert property (p_hold) else $error("request changed while stalled");
  property p_ld_wr; req_valid && (req_addr == REG_HDR || req_addr == REG_PAY) |-> req_write; endproperty
  a_ld_wr: assert property (p_ld_wr) else $error("load register read");
  property p_ver; lo_t && req_addr == REG_VER |=> rsp_byte == 8'h01; endproperty
  a_ver: assert property (p_ver) else $error("version byte wrong");
  property p_unmap; rd_t && req_addr == 8'h03 |=> rsp_byte == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // Top two bits are only set by the two whole-byte codes
  property p_st_lo;
    lo_t && req_addr == REG_STATUS |=> rsp_byte[7:6] == 2'b00 ||
      rsp_byte == ST_EOL_CODE || rsp_byte == ST_DIV_CODE;
  endproperty
  a_st_lo: assert property (p_st_lo) else $error("status low byte malformed");
endmodule

// *** tb/memory_download_access_port_test.sv ***
`timescale 1ns/1ps
module memory_download_access_port_test;
  import mdap_pkg::*;
  // ----------------------------------------
  // Stimulus, far-side responders, checks
  // ----------------------------------------
  localparam logic [63:0] PEEK_WORD = 64'h0123_4567_89AB_CDEF;  // Memory answer
  logic        core_clk = 1'b0, nrst = 1'b0, div_show = 1'b0;
  logic        cmd_valid = 1'b0, cmd_write = 1'b0, cmd_cks = 1'b0;
  logic        mem_wr_ready = 1'b0, pp_done = 1'b0, mem_hold = 1'b0;
  logic [31:0] last_ma = 32'h0;  // Last memory select and address
  logic [7:0]  cmd_addr = 8'h00;
  logic [3:0]  cmd_len = 4'h0;
  logic [63:0] cmd_data = 64'h0, last_mem = 64'h0;
  logic [24:0] pp_tag = 25'h0;  // Last kind, target, address seen
  logic        cmd_ready, rsp_valid, mem_wr_valid, pp_valid, pp_write;
  logic [63:0] rsp_data, mem_data, pp_wdata;
  logic [15:0] mem_sel, mem_addr, pp_addr;
  logic [7:0]  pp_sel;
  int          n_errors = 0, n_tests = 0;
  always #5 core_clk = ~core_clk;
  mdap_if mdap_if_i ();
  mdap_dev mdap_dev_i (.core_clk(core_clk), .nrst(nrst), .lnk(mdap_if_i), .fw_status(24'h0),
    .div_show(div_show), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_sel(mem_sel), .mem_addr(mem_addr), .mem_data(mem_data), .pp_valid(pp_valid),
    .pp_write(pp_write), .pp_sel(pp_sel), .pp_addr(pp_addr), .pp_wdata(pp_wdata),
    .pp_done(pp_done), .pp_rdata(PEEK_WORD));
  mdap_host mdap_host_i (.core_clk(core_clk), .nrst(nrst), .lnk(mdap_if_i),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .cmd_data(cmd_data), .cmd_cks(cmd_cks), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  mdap_chk mdap_chk_i (.core_clk(core_clk), .nrst(nrst), .req_valid(mdap_if_i.req_valid),
    .req_ready(mdap_if_i.req_ready), .req_write(mdap_if_i.req_write),
    .req_addr(mdap_if_i.req_addr), .req_idx(mdap_if_i.req_idx),
    .req_wbyte(mdap_if_i.req_wbyte), .rsp_valid(mdap_if_i.rsp_valid),
    .rsp_byte(mdap_if_i.rsp_byte));
  // Memory port stalls every other cycle so words back up in the FIFO
  always @(posedge core_clk) begin
    mem_wr_ready <= ~mem_wr_ready & ~mem_hold;
    pp_done      <= pp_valid & ~pp_done;
    if (mem_wr_valid && mem_wr_ready) {last_ma, last_mem} <= {mem_sel, mem_addr, mem_data};
    if (pp_valid) pp_tag <= {pp_write, pp_sel, pp_addr};
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One host command, held until taken, then its completion pulse
  task automatic cmd(input logic w, input logic [7:0] a, input logic [3:0] l,
                     input logic [63:0] d, input logic c);
    @(posedge core_clk);
    {cmd_valid, cmd_write, cmd_addr, cmd_len, cmd_data, cmd_cks} <= {1'b1, w, a, l, d, c};
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    for (int t = 0; t < 300 && rsp_valid !== 1'b1; t++) @(posedge core_clk);
    chk({63'h0, rsp_valid}, 64'h1);
  endtask
  task automatic st(input logic [7:0] e);
    cmd(1'b0, REG_STATUS, 4'h4, 64'h0, 1'b0);
    chk(rsp_data, {56'h0, e});
  endtask
  task automatic wait_pp(input logic lvl);
    for (int t = 0; t < 50 && pp_valid !== lvl; t++) @(posedge core_clk);
  endtask
  task automatic t_reset();
    cmd(1'b0, REG_VER, 4'h4, 64'h0, 1'b0);
    chk(rsp_data, 64'h1);
    cmd(1'b0, 8'h03, 4'h4, 64'h0, 1'b0);
    chk(rsp_data, 64'h0);
    st(8'h00);
  endtask
  // Two byte words; sum is 0x10 + 0x02 + 0xA5 + 0x5A
  task automatic t_load_ok();
    cmd(1'b1, REG_HDR, 4'h8, 64'h0111_0000_0010_0002, 1'b0);
    st(8'h01);
    cmd(1'b1, REG_PAY, 4'h2, 64'hA55A_0000_0000_0000, 1'b0);
    cmd(1'b1, REG_PAY, 4'h2, 64'h0, 1'b1);
    st(8'h00);
    chk(last_mem, 64'h5A);
  endtask
  task automatic t_bad_cks();
    cmd(1'b1, REG_HDR, 4'h8, 64'h0BAD_0001_0020_0001, 1'b0);
    cmd(1'b1, REG_PAY, 4'h1, 64'h1100_0000_0000_0000, 1'b0);
    cmd(1'b1, REG_PAY, 4'h2, 64'h0, 1'b1);
    st(8'h02);
    cmd(1'b1, REG_HDR, 4'h8, 64'h0000_0007_0000_0001, 1'b0);
    st(8'h22);
  endtask
  task automatic t_eol();
    cmd(1'b1, REG_HDR, 4'h8, 64'h1234_0002_0000_0008, 1'b0);
    cmd(1'b1, REG_HDR, 4'h8, 64'h0, 1'b0);
    st(ST_EOL_CODE);
    div_show <= 1'b1;
    st(ST_DIV_CODE);
    div_show <= 1'b0;
  endtask
  // Memory port held busy so the FIFO fills and the link stalls
  task automatic t_stall();
    mem_hold <= 1'b1;
    cmd(1'b1, REG_HDR, 4'h8, 64'h0085_0001_0000_0018, 1'b0);
    repeat (2) cmd(1'b1, REG_PAY, 4'h8, 64'h0102_0304_0506_0708, 1'b0);
    fork
      cmd(1'b1, REG_PAY, 4'h8, 64'h0102_0304_0506_0708, 1'b0);
      begin
        repeat (20) @(posedge core_clk);
        mem_hold <= 1'b0;
      end
    join
    cmd(1'b1, REG_PAY, 4'h2, 64'h0, 1'b1);
    repeat (60) @(posedge core_clk);
    st(8'h04);
    chk({32'h0, last_ma}, {32'h0, MSEL_UXDATA, 16'h0017});
    chk(last_mem, 64'h08);
  endtask
  // Address field is bit-reversed: 0x0001 targets 0x8000
  task automatic t_peek_poke();
    cmd(1'b1, REG_SA, 4'h4, 64'h0001_0001_0000_0000, 1'b0);
    wait_pp(1'b1);
    wait_pp(1'b0);
    chk({39'h0, pp_tag}, {39'h0, 1'b0, PP_DCOEF, 16'h8000});
    cmd(1'b0, REG_PPD, 4'h8, 64'h0, 1'b0);
    chk(rsp_data, PEEK_WORD);
    cmd(1'b1, REG_PPD, 4'h8, 64'hFEDC_BA98_7654_3210, 1'b0);
    wait_pp(1'b1);
    chk(pp_wdata, 64'hFEDC_BA98_7654_3210);
    wait_pp(1'b0);
    chk({39'h0, pp_tag}, {39'h0, 1'b1, PP_DCOEF, 16'h8000});
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_load_ok();
    t_bad_cks();
    t_eol();
    t_stall();
    t_peek_poke();
    end_of_test();
  end
  // Whole run needs well under a thousand cycles; this allows 30000
  initial begin
    #300000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
